// File: hdl/uft_pkg.sv
// shared constants for the serial frame transmitter
package uft_pkg;
  // register byte offsets
  localparam logic [7:0] UFT_DATA_OFS = 8'h00;
  localparam logic [7:0] UFT_CTRLB_OFS = 8'h04;
  localparam logic [7:0] UFT_CTRLC_OFS = 8'h08;
  localparam logic [7:0] UFT_STAT_OFS = 8'h0C;
  localparam logic [7:0] UFT_BAUD_OFS = 8'h10;
  // control_reg_b fields
  localparam int B_NINTH = 0;
  localparam int B_EMPTY_IE = 1;
  localparam int B_DONE_IE = 2;
  localparam int B_TX_EN = 3;
  // control_reg_c fields
  localparam int C_CSZ_LO = 0;
  localparam int C_PM_LO = 4;
  localparam int C_STOP2 = 6;
  localparam int C_SYNC = 7;
  localparam int C_SLAVE = 8;
  // status fields
  localparam int S_EMPTY = 0;
  localparam int S_DONE = 1;
  localparam int S_DBL = 2;
  // parity_mode_sel bits
  localparam int PM_EN = 1;
  localparam int PM_ODD = 0;
  // character size codes
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [3:0] CSZ_BASE = 4'h5;
  localparam logic [3:0] NINE_BITS = 4'h9;
  localparam logic [8:0] DATA_ALL = 9'h1FF;
  // reset values
  localparam logic [2:0] CSZ_RST = 3'h6;
  localparam logic [11:0] DIV_RST = 12'h000;
  // baud ticks per bit in each clock mode
  localparam logic [4:0] PER_NORMAL = 5'h10;
  localparam logic [4:0] PER_DOUBLE = 5'h08;
  localparam logic [4:0] PER_SYNC = 5'h02;
  // transmit sequencer
  typedef enum logic [4:0] {
    UFT_IDLE = 5'h01,
    UFT_START = 5'h02,
    UFT_DATA = 5'h04,
    UFT_PAR = 5'h08,
    UFT_STOP = 5'h10
  } uft_state_t;
endpackage

// File: hdl/uft_bit_clock.sv
// bit clock: baud divider, mode prescaler and external clock edges
`timescale 1ns/1ps
module uft_bit_clock #(
  parameter int DIV_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic double_speed,
  input wire logic sync_mode,
  input wire logic sync_slave,
  input wire logic restart,
  input wire logic ext_clk_i,
  output logic bit_tick,
  output logic clk_level
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic [4:0] pre;
    logic [2:0] ext;
    logic tick;
  } uft_clk_t;

  uft_clk_t q, d;
  logic [4:0] per;

  always_comb begin
    d = q;
    per = sync_mode ? uft_pkg::PER_SYNC :
          double_speed ? uft_pkg::PER_DOUBLE : uft_pkg::PER_NORMAL;
    // ext[0] feeds only ext[1]; edges are found on ext[2:1]
    d.ext = {q.ext[1:0], ext_clk_i};
    d.tick = 1'b0;
    if (q.cnt == '0) begin
      d.cnt = divisor;
    end else begin
      d.cnt = q.cnt - 1'b1;
    end
    if (sync_mode && sync_slave) begin
      d.tick = q.ext[1] & ~q.ext[2];
    end else if (q.cnt == '0) begin
      if (q.pre == per - 5'h01) begin
        d.pre = '0;
        d.tick = 1'b1;
      end else begin
        d.pre = q.pre + 5'h01;
      end
    end
    // frame start re-phases the prescaler; a tick already due in that same cycle still fires
    if (restart) begin
      d.pre = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bit_tick = q.tick;
  assign clk_level = q.pre[0];
endmodule

// File: hdl/uft_transmitter.sv
// serial frame transmitter with apb register file
// Operation
// - all 30 formats: 5..9 data bits, none/even/odd parity, 1/2 stops
// - frame sends start bit then data bits lsb first
// - parity bit sits after last data bit, before first stop
// - start bit driven low, stop bits driven high
// - next frame may follow back to back, else line idles high
// - size, parity mode and stop select fields shape the frame
// - one shared format; changing it mid-frame may corrupt transfers
// - receiver checks only the first stop bit for framing errors
// - even parity is xor of data bits, odd is its inverse
// - transmit enable takes over the serial output pin
// - sync master mode (not slave) with transmit enabled overrides the clock pin
// - data write fills buffer; moves to shifter when idle or after stop
// - shifter sends one frame timed by baud, double speed or ext clock
// - data bits above the character size are ignored
// - size code 7 takes ninth bit from control; software sets it first
// - empty flag set while buffer empty, cleared by write; irq level
// - done flag sets after frame with buffer empty; ack or w1c clears
// - disable waits for shifter and buffer to drain, then frees pin
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module uft_transmitter #(
  parameter int ADDR_W = 8,
  parameter int DIV_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  input wire logic sync_clock_pin_i,
  output logic sync_clock_pin_o,
  output logic sync_clock_pin_oe,
  output logic tx_empty_irq,
  output logic tx_complete_irq,
  input wire logic tx_complete_ack
);
  typedef struct packed {
    uft_pkg::uft_state_t st;
    logic [8:0] buf_data;
    logic buf_full;
    logic [8:0] sh;
    logic [3:0] cnt;
    logic par;
    logic line;
    logic oe;
    logic xck;
    logic xck_oe;
    logic done;
    logic irq_e;
    logic irq_c;
    logic ninth;
    logic empty_ie;
    logic done_ie;
    logic tx_en;
    logic [2:0] csz;
    logic [1:0] pm;
    logic stop2;
    logic sync;
    logic slave;
    logic dbl;
    logic [DIV_W-1:0] div;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } uft_regs_t;

  uft_regs_t q, d;

  logic bit_tick;
  logic clk_level;
  logic acc;
  logic wr;
  logic rd;
  logic load;
  logic [3:0] nbits;
  logic [8:0] mask;
  logic [7:0] ofs;
  logic mapped;

  uft_bit_clock #(
    .DIV_W(DIV_W)
  ) u_clk (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(q.div),
    .double_speed(q.dbl),
    .sync_mode(q.sync),
    .sync_slave(q.slave),
    .restart(load),
    .ext_clk_i(sync_clock_pin_i),
    .bit_tick(bit_tick),
    .clk_level(clk_level)
  );

  // data width from the size code; codes 4..6 act as eight bits
  function automatic logic [3:0] width_of(input logic [2:0] c);
    if (c == uft_pkg::CSZ_NINE) begin
      return uft_pkg::NINE_BITS;
    end else if (c[2]) begin
      return uft_pkg::NINE_BITS - 4'h1;
    end else begin
      return uft_pkg::CSZ_BASE + {2'b00, c[1:0]};
    end
  endfunction

  always_comb begin
    d = q;
    ofs = '0;
    ofs[ADDR_W-1:0] = paddr;
    acc = psel & penable & q.ready;
    wr = acc & pwrite;
    rd = psel & penable & ~q.ready & ~pwrite;
    nbits = width_of(q.csz);
    mask = uft_pkg::DATA_ALL >> (uft_pkg::NINE_BITS - nbits);
    load = 1'b0;
    mapped = (ofs == uft_pkg::UFT_DATA_OFS) ||
             (ofs == uft_pkg::UFT_CTRLB_OFS) ||
             (ofs == uft_pkg::UFT_CTRLC_OFS) ||
             (ofs == uft_pkg::UFT_STAT_OFS) ||
             (ofs == uft_pkg::UFT_BAUD_OFS);

    // apb: one wait state, then a registered answer
    d.ready = psel & penable & ~q.ready;
    d.err = psel & penable & ~q.ready & ~mapped;
    d.rdata = '0;
    if (rd) begin
      case (ofs)
        uft_pkg::UFT_CTRLB_OFS: begin
          d.rdata[uft_pkg::B_NINTH] = q.ninth;
          d.rdata[uft_pkg::B_EMPTY_IE] = q.empty_ie;
          d.rdata[uft_pkg::B_DONE_IE] = q.done_ie;
          d.rdata[uft_pkg::B_TX_EN] = q.tx_en;
        end
        uft_pkg::UFT_CTRLC_OFS: begin
          d.rdata[uft_pkg::C_CSZ_LO +: 3] = q.csz;
          d.rdata[uft_pkg::C_PM_LO +: 2] = q.pm;
          d.rdata[uft_pkg::C_STOP2] = q.stop2;
          d.rdata[uft_pkg::C_SYNC] = q.sync;
          d.rdata[uft_pkg::C_SLAVE] = q.slave;
        end
        uft_pkg::UFT_STAT_OFS: begin
          d.rdata[uft_pkg::S_EMPTY] = ~q.buf_full;
          d.rdata[uft_pkg::S_DONE] = q.done;
          d.rdata[uft_pkg::S_DBL] = q.dbl;
        end
        uft_pkg::UFT_BAUD_OFS: begin
          d.rdata[DIV_W-1:0] = q.div;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end

    // one format set shared with the receive side; live changes
    // take effect at once and may garble a frame in flight
    if (wr) begin
      case (ofs)
        uft_pkg::UFT_CTRLB_OFS: begin
          d.ninth = pwdata[uft_pkg::B_NINTH];
          d.empty_ie = pwdata[uft_pkg::B_EMPTY_IE];
          d.done_ie = pwdata[uft_pkg::B_DONE_IE];
          d.tx_en = pwdata[uft_pkg::B_TX_EN];
        end
        uft_pkg::UFT_CTRLC_OFS: begin
          d.csz = pwdata[uft_pkg::C_CSZ_LO +: 3];
          d.pm = pwdata[uft_pkg::C_PM_LO +: 2];
          d.stop2 = pwdata[uft_pkg::C_STOP2];
          d.sync = pwdata[uft_pkg::C_SYNC];
          d.slave = pwdata[uft_pkg::C_SLAVE];
        end
        uft_pkg::UFT_STAT_OFS: begin
          d.dbl = pwdata[uft_pkg::S_DBL];
          if (pwdata[uft_pkg::S_DONE]) begin
            d.done = 1'b0;
          end
        end
        uft_pkg::UFT_BAUD_OFS: begin
          d.div = pwdata[DIV_W-1:0];
        end
        default: begin
          d.div = q.div;
        end
      endcase
    end
    if (tx_complete_ack) begin
      d.done = 1'b0;
    end

    // frame sequencer
    case (q.st)
      uft_pkg::UFT_IDLE: begin
        d.line = 1'b1;
        if (q.buf_full && q.tx_en) begin
          load = 1'b1;
        end
      end
      uft_pkg::UFT_START: begin
        if (bit_tick) begin
          d.line = q.sh[0];
          d.sh = {1'b0, q.sh[8:1]};
          d.cnt = 4'h1;
          d.st = uft_pkg::UFT_DATA;
        end
      end
      uft_pkg::UFT_DATA: begin
        if (bit_tick) begin
          if (q.cnt >= nbits) begin
            if (q.pm[uft_pkg::PM_EN]) begin
              d.line = q.par;
              d.st = uft_pkg::UFT_PAR;
            end else begin
              d.line = 1'b1;
              d.st = uft_pkg::UFT_STOP;
            end
            d.cnt = '0;
          end else begin
            d.line = q.sh[0];
            d.sh = {1'b0, q.sh[8:1]};
            d.cnt = q.cnt + 4'h1;
          end
        end
      end
      uft_pkg::UFT_PAR: begin
        if (bit_tick) begin
          d.line = 1'b1;
          d.st = uft_pkg::UFT_STOP;
        end
      end
      uft_pkg::UFT_STOP: begin
        d.line = 1'b1;
        if (bit_tick) begin
          // both stops are high so a far end that checks only the
          // first one sees a clean frame either way
          if (q.stop2 && q.cnt == '0) begin
            d.cnt = 4'h1;
          end else if (q.buf_full) begin
            load = 1'b1;
          end else begin
            d.st = uft_pkg::UFT_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default: begin
        d.st = uft_pkg::UFT_IDLE;
      end
    endcase

    if (load) begin
      d.sh = q.buf_data & mask;
      // xor of the sent bits, inverted for odd parity
      d.par = ^(q.buf_data & mask) ^ q.pm[uft_pkg::PM_ODD];
      d.buf_full = 1'b0;
      d.line = 1'b0;
      d.cnt = '0;
      d.st = uft_pkg::UFT_START;
    end
    // a write landing as the shifter empties the buffer still counts
    if (wr && ofs == uft_pkg::UFT_DATA_OFS) begin
      d.buf_data = {q.ninth, pwdata[7:0]};
      d.buf_full = 1'b1;
    end

    // pin stays claimed until shifter and buffer are drained
    d.oe = q.tx_en || d.st != uft_pkg::UFT_IDLE || d.buf_full;
    if (!d.oe) begin
      d.line = 1'b1;
    end
    d.xck_oe = q.tx_en & q.sync & ~q.slave;
    d.xck = clk_level & d.xck_oe;
    d.irq_e = ~d.buf_full & q.empty_ie;
    d.irq_c = d.done & q.done_ie;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= uft_pkg::UFT_IDLE;
      q.line <= 1'b1;
      q.csz <= uft_pkg::CSZ_RST;
      q.div <= uft_pkg::DIV_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign serial_out_pin_o = q.line;
  assign serial_out_pin_oe = q.oe;
  assign sync_clock_pin_o = q.xck;
  assign sync_clock_pin_oe = q.xck_oe;
  assign tx_empty_irq = q.irq_e;
  assign tx_complete_irq = q.irq_c;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic data_wr;
  assign data_wr = wr && ofs == uft_pkg::UFT_DATA_OFS;

  property p_start_low;
    q.st == uft_pkg::UFT_START |-> !serial_out_pin_o;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_stop_high;
    q.st == uft_pkg::UFT_STOP |-> serial_out_pin_o;
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("stop bit not high");

  property p_idle_high;
    q.st == uft_pkg::UFT_IDLE && !load |=>
      q.st != uft_pkg::UFT_IDLE || serial_out_pin_o;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("idle line not high");

  property p_lsb_first;
    q.st == uft_pkg::UFT_START && bit_tick |=>
      serial_out_pin_o == $past(q.sh[0]) && q.st == uft_pkg::UFT_DATA;
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("first data bit not lsb");

  sequence s_last_data;
    q.st == uft_pkg::UFT_DATA && bit_tick && q.cnt >= nbits;
  endsequence
  property p_parity_slot;
    s_last_data ##0 q.pm[uft_pkg::PM_EN] |=>
      q.st == uft_pkg::UFT_PAR && serial_out_pin_o == q.par;
  endproperty
  a_parity_slot: assert property (p_parity_slot)
    else $error("parity bit misplaced");

  property p_parity_value;
    load |=> q.par == (^(q.sh) ^ q.pm[uft_pkg::PM_ODD]);
  endproperty
  a_parity_value: assert property (p_parity_value)
    else $error("parity value wrong");

  property p_write_fills;
    data_wr |=> q.buf_full && !tx_empty_irq;
  endproperty
  a_write_fills: assert property (p_write_fills)
    else $error("write did not fill buffer");

  property p_empty_irq;
    ##1 tx_empty_irq == $past(!d.buf_full && q.empty_ie);
  endproperty
  a_empty_irq: assert property (p_empty_irq)
    else $error("empty irq level wrong");

  property p_release;
    $fell(serial_out_pin_oe) |->
      q.st == uft_pkg::UFT_IDLE && !q.buf_full && !q.tx_en;
  endproperty
  a_release: assert property (p_release)
    else $error("pin released with data pending");

  property p_enable_claims;
    q.tx_en |=> serial_out_pin_oe;
  endproperty
  a_enable_claims: assert property (p_enable_claims)
    else $error("pin not claimed while enabled");

  property p_done_set;
    q.st == uft_pkg::UFT_STOP && bit_tick && !q.buf_full &&
      !(q.stop2 && q.cnt == '0) |=> q.done;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag not set");
endmodule

// File: test/uft_rx_model.sv
// remote serial receiver model sampling the transmit line mid-bit
`timescale 1ns/1ps
module uft_rx_model (
  input wire logic pclk,
  input wire logic line,
  input wire logic [7:0] bit_len,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  input wire logic two_stop,
  output logic [8:0] rx_data,
  output logic rx_par,
  output logic rx_start_low,
  output logic rx_fe,
  output logic rx_stop2,
  output logic [7:0] rx_cnt,
  output logic [31:0] rx_t0
);
  logic [31:0] cyc = 32'h0;
  always @(posedge pclk) cyc <= cyc + 1;
  initial rx_cnt = 8'h00;
  // results are published before the count moves, so a reader
  // that sees the count change also sees the frame
  always begin
    @(posedge pclk);
    if (line === 1'b0) begin
      rx_t0 = cyc;
      rx_data = 9'h000;
      repeat (bit_len / 2) @(posedge pclk);
      rx_start_low = (line === 1'b0);
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_len) @(posedge pclk);
        rx_data[i] = line;
      end
      if (par_en) begin
        repeat (bit_len) @(posedge pclk);
        rx_par = line;
      end
      repeat (bit_len) @(posedge pclk);
      rx_fe = (line !== 1'b1);
      rx_stop2 = 1'b1;
      if (two_stop) begin
        // a second stop never counts as a framing error
        repeat (bit_len) @(posedge pclk);
        rx_stop2 = line;
      end
      rx_cnt = rx_cnt + 1;
    end
  end
endmodule

// File: test/tb_usart_frame_transmitter.sv
// self-checking bench for the serial frame transmitter
`timescale 1ns/1ps
module tb_usart_frame_transmitter;
  typedef struct packed {
    logic [2:0] csz;
    logic [1:0] pm;
    logic s2;
    logic [8:0] d;
    logic [3:0] n;
  } uft_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, so, soe, ck_oe, e_irq, c_irq, ack = 0;
  logic line, rpar, rsl, rfe, rs2, pe = 0, s2 = 0;
  logic [3:0] nb = 4'h8;
  logic [8:0] rdat, m;
  logic [7:0] rcnt;
  logic [7:0] blen = 8'h10;
  logic [31:0] rt0, t1;
  int errors = 0, total_checks = 0, k;
  uft_row_t r;
  uft_row_t rows [5] = '{
    '{3'h0, 2'h0, 1'b0, 9'h0FF, 4'h5}, '{3'h1, 2'h2, 1'b1, 9'h0A5, 4'h6},
    '{3'h2, 2'h3, 1'b0, 9'h0BC, 4'h7}, '{3'h3, 2'h2, 1'b1, 9'h181, 4'h8},
    '{3'h7, 2'h3, 1'b1, 9'h1A5, 4'h9}};
  always #10 pclk = ~pclk;
  // released line is pulled up
  assign line = soe ? so : 1'b1;
  uft_transmitter u_uft_transmitter (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_out_pin_o(so), .serial_out_pin_oe(soe),
    .sync_clock_pin_i(1'b0), .sync_clock_pin_o(),
    .sync_clock_pin_oe(ck_oe), .tx_empty_irq(e_irq),
    .tx_complete_irq(c_irq), .tx_complete_ack(ack));
  uft_rx_model u_uft_rx_model (.pclk(pclk), .line(line), .bit_len(blen),
    .nbits(nb), .par_en(pe), .two_stop(s2), .rx_data(rdat), .rx_par(rpar),
    .rx_start_low(rsl), .rx_fe(rfe), .rx_stop2(rs2), .rx_cnt(rcnt),
    .rx_t0(rt0));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_frame();
    logic [7:0] c;
    int n;
    c = rcnt;
    n = 0;
    while (rcnt === c && n < 5000) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 5000) chk("frame", 32'h1, 32'h0);
    @(posedge pclk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, uft_pkg::UFT_STAT_OFS, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 10);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("oe", 32'h0, soe);
    chk("line", 32'h1, so);
    @(posedge pclk);
    apb(1'b0, uft_pkg::UFT_CTRLC_OFS, 32'h0);
    chk("ctrlc", 32'h6, rd);
    apb(1'b0, uft_pkg::UFT_STAT_OFS, 32'h0);
    chk("status", 32'h1, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'h1, err);
    apb(1'b1, uft_pkg::UFT_BAUD_OFS, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      nb = r.n;
      pe = r.pm[1];
      s2 = r.s2;
      apb(1'b1, uft_pkg::UFT_CTRLC_OFS, {25'h0, r.s2, r.pm, 1'b0, r.csz});
      apb(1'b1, uft_pkg::UFT_CTRLB_OFS, {28'h0, 3'b100, r.d[8]});
      apb(1'b1, uft_pkg::UFT_STAT_OFS, 32'h2);
      apb(1'b1, uft_pkg::UFT_DATA_OFS, {24'h0, r.d[7:0]});
      wait_frame();
      m = r.d & (9'h1FF >> (9 - r.n));
      chk("data", m, rdat);
      if (pe) chk("parity", ^m ^ r.pm[0], rpar);
      chk("start", 32'h1, rsl);
      chk("fe", 32'h0, rfe);
      chk("stop2", 32'h1, rs2);
      wait_done();
      chk("status", 32'h3, rd);
      chk("oe", 32'h1, soe);
      $display("test row %0d done", i);
    end
    nb = 4'h8;
    pe = 1'b0;
    s2 = 1'b0;
    apb(1'b1, uft_pkg::UFT_CTRLC_OFS, 32'h3);
    apb(1'b1, uft_pkg::UFT_CTRLB_OFS, 32'hA);
    apb(1'b1, uft_pkg::UFT_STAT_OFS, 32'h2);
    apb(1'b1, uft_pkg::UFT_DATA_OFS, 32'h55);
    apb(1'b1, uft_pkg::UFT_DATA_OFS, 32'hC3);
    apb(1'b0, uft_pkg::UFT_STAT_OFS, 32'h0);
    chk("status", 32'h0, rd);
    @(negedge pclk);
    chk("empty_irq", 32'h0, e_irq);
    @(posedge pclk);
    wait_frame();
    t1 = rt0;
    chk("data", 32'h55, rdat);
    wait_frame();
    chk("data", 32'hC3, rdat);
    // ten bits of sixteen clocks; start bit runs one clock longer, seventeen clocks
    k = rt0 - t1;
    chk("gap", 32'h1, k >= 159 && k <= 161);
    @(negedge pclk);
    chk("empty_irq", 32'h1, e_irq);
    @(posedge pclk);
    apb(1'b1, uft_pkg::UFT_CTRLB_OFS, 32'hC);
    wait_done();
    @(negedge pclk);
    chk("done_irq", 32'h1, c_irq);
    @(posedge pclk);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    @(posedge pclk);
    apb(1'b0, uft_pkg::UFT_STAT_OFS, 32'h0);
    chk("status", 32'h1, rd);
    $display("test back_to_back done");
    apb(1'b1, uft_pkg::UFT_DATA_OFS, 32'hF0);
    apb(1'b1, uft_pkg::UFT_CTRLB_OFS, 32'h0);
    chk("oe", 32'h1, soe);
    wait_frame();
    chk("data", 32'hF0, rdat);
    k = 0;
    while (soe !== 1'b0 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    chk("oe", 32'h0, soe);
    chk("line", 32'h1, so);
    $display("test disable done");
    // double speed halves the bit period to eight clocks
    blen = 8'h08;
    apb(1'b1, uft_pkg::UFT_CTRLB_OFS, 32'h8);
    apb(1'b1, uft_pkg::UFT_STAT_OFS, 32'h4);
    apb(1'b1, uft_pkg::UFT_DATA_OFS, 32'h3C);
    wait_frame();
    chk("data", 32'h3C, rdat);
    chk("fe", 32'h0, rfe);
    wait_done();
    apb(1'b1, uft_pkg::UFT_STAT_OFS, 32'h2);
    apb(1'b1, uft_pkg::UFT_CTRLB_OFS, 32'h0);
    blen = 8'h10;
    $display("test double_speed done");
    @(posedge pclk);
    apb(1'b1, uft_pkg::UFT_CTRLC_OFS, 32'h83);
    apb(1'b1, uft_pkg::UFT_CTRLB_OFS, 32'h8);
    @(negedge pclk);
    chk("clk_oe", 32'h1, ck_oe);
    @(posedge pclk);
    apb(1'b1, uft_pkg::UFT_CTRLB_OFS, 32'h0);
    $display("test sync done");
    end_of_test();
  end
endmodule
